//--- logic/uhie_pkg.sv
/*
   Shared definitions of the interrupt enable and mask block of the USB host controller:
   register offsets, bit positions, reset values and the event and request carriers.
   Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
*/
`default_nettype none
package uhie_pkg;

   // ------------------------------------------------------------------
   // Register map.
   // ------------------------------------------------------------------
   localparam logic [7:0] UHIE_OFS_STATUS = 8'h0c;
   localparam logic [7:0] UHIE_OFS_ENABLE_SET = 8'h10;
   localparam logic [7:0] UHIE_OFS_ENABLE_CLEAR = 8'h14;
   localparam int UHIE_ADDR_W = 8;

   // ------------------------------------------------------------------
   // Bit positions of the enable register; all but the gate are shared with the status register.
   // ------------------------------------------------------------------
   localparam int UHIE_POS_GATE = 31;
   localparam int UHIE_POS_OWN = 30;
   localparam int UHIE_POS_HUB = 6;
   localparam int UHIE_POS_FNO = 5;
   localparam int UHIE_POS_FATAL = 4;
   localparam int UHIE_POS_RESUME = 3;
   localparam int UHIE_POS_SOF = 2;
   localparam int UHIE_POS_DONE = 1;
   localparam int UHIE_POS_OVR = 0;

   // Positions that carry an event source.
   localparam logic [31:0] UHIE_EVT_MASK = 32'h4000_007f;

   // Reset values of the stored registers.
   localparam logic [31:0] UHIE_ENABLE_RST = 32'h0000_0000;
   localparam logic [31:0] UHIE_STATUS_RST = 32'h0000_0000;

   // AHB-Lite encodings.
   localparam logic [1:0] UHIE_HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] UHIE_HTRANS_SEQ = 2'h3;
   localparam logic UHIE_HRESP_OKAY = 1'h0;

   // One-cycle event pulses from the rest of the controller.
   typedef struct packed {
      logic ownership_change;
      logic root_hub_change;
      logic frame_number_overflow;
      logic fatal_system_error;
      logic resume_detect;
      logic frame_start;
      logic done_queue_writeback;
      logic sched_overrun;
   } uhie_evt_s;

   // Latched address phase of an AHB transfer.
   typedef struct packed {
      logic valid;
      logic write;
      logic [UHIE_ADDR_W-1:0] addr;
   } uhie_aphase_s;

endpackage
`default_nettype wire

//--- logic/uhie_irq_mask.sv
/*
   Interrupt enable mask of a USB host controller: an enable register with write-one-to-set
   access, a clear port with write-one-to-clear access that reads back the enable register,
   a sticky status register and the level interrupt output.
   Assumes a single AHB-Lite master, word transfers only, and event pulses synchronous to hclk.
*/
// Functional notes
// - Bit 31 gates every interrupt request.
// - Bit 30 enables ownership change requests.
// - Bit 6 enables root hub change requests.
// - Bit 5 enables frame number overflow.
// - Bit 4 enables fatal system error requests.
// - Bit 3 enables resume detection requests.
// - Bit 2 enables frame start requests.
// - Bit 1 enables done queue writeback requests.
// - Bit 0 enables scheduling overrun requests.
// - Enable writes set ones, never clear.
// - Clear-port writes clear bits written one.
// - Clear-port reads return the enable register.
// - Enable bit maps to same status bit.
// - Interrupt needs status, enable and gate.
// - Frame start sets status; zero write clears.
`timescale 1ns/10ps
`default_nettype none
module uhie_irq_mask
   import uhie_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire uhie_evt_s events,
   output logic irq
);

   // ------------------------------------------------------------------
   // Helper functions.
   // ------------------------------------------------------------------

   // Places the event pulses at their register positions.
   function automatic logic [31:0] evt_vec(input uhie_evt_s e);
      logic [31:0] v;
      v = 32'h0000_0000;
      v[UHIE_POS_OWN] = e.ownership_change;
      v[UHIE_POS_HUB] = e.root_hub_change;
      v[UHIE_POS_FNO] = e.frame_number_overflow;
      v[UHIE_POS_FATAL] = e.fatal_system_error;
      v[UHIE_POS_RESUME] = e.resume_detect;
      v[UHIE_POS_SOF] = e.frame_start;
      v[UHIE_POS_DONE] = e.done_queue_writeback;
      v[UHIE_POS_OVR] = e.sched_overrun;
      return v;
   endfunction

   // Read decode; unmapped offsets read as zero.
   function automatic logic [31:0] rd_mux(input logic [UHIE_ADDR_W-1:0] a, input logic [31:0] en,
                                          input logic [31:0] st);
      logic [31:0] r;
      r = 32'h0000_0000;
      case (a)
         UHIE_OFS_STATUS: r = st;
         UHIE_OFS_ENABLE_SET: r = en;
         UHIE_OFS_ENABLE_CLEAR: r = en;
         default: r = 32'h0000_0000;
      endcase
      return r;
   endfunction

   // ------------------------------------------------------------------
   // Bus slave.
   // ------------------------------------------------------------------
   uhie_aphase_s ap_q;
   uhie_aphase_s ap_d;
   logic [31:0] hrdata_q;
   logic [31:0] hrdata_d;
   logic [31:0] en_q;
   logic [31:0] en_d;
   logic [31:0] st_q;
   logic [31:0] st_d;
   logic take;
   logic wr_set;
   logic wr_clr;
   logic wr_st;
   logic [31:0] evt_now;

   // The slave never stretches a transfer, so hready is only honoured as the bus's own pacing.
   assign hreadyout = 1'b1;
   assign hresp = UHIE_HRESP_OKAY;
   assign hrdata = hrdata_q;

   // A transfer is taken when the address phase is valid at a ready edge; hsize is not checked
   // because only whole-word transfers reach this block.
   assign take = hsel && hready && (htrans == UHIE_HTRANS_NONSEQ || htrans == UHIE_HTRANS_SEQ);

   // Write strobes for the data phase that follows a taken write.
   // Only the low address byte is decoded, so the registers alias across the rest of the space.
   assign wr_set = ap_q.valid && ap_q.write && (ap_q.addr == UHIE_OFS_ENABLE_SET);
   assign wr_clr = ap_q.valid && ap_q.write && (ap_q.addr == UHIE_OFS_ENABLE_CLEAR);
   assign wr_st = ap_q.valid && ap_q.write && (ap_q.addr == UHIE_OFS_STATUS);

   // Read data is taken from the next register values, so a read right behind a write
   // already sees that write without any wait state.
   // The price is a longer path from hwdata to hrdata_q, which stays short at this width.
   always_comb begin
      ap_d.valid = take;
      ap_d.write = hwrite;
      ap_d.addr = haddr[UHIE_ADDR_W-1:0];
      hrdata_d = hrdata_q;
      if (take && !hwrite) begin
         hrdata_d = rd_mux(haddr[UHIE_ADDR_W-1:0], en_d, st_d);
      end
   end

   // Address phase and read data registers.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_q <= '0;
         hrdata_q <= 32'h0000_0000;
      end else begin
         ap_q <= ap_d;
         hrdata_q <= hrdata_d;
      end
   end

   // ------------------------------------------------------------------
   // Enable register.
   // ------------------------------------------------------------------

   // Reserved bits are stored as written; software is expected to keep them at zero and
   // they never take part in the interrupt.
   // Set and clear never meet in one cycle, since a data phase carries a single address.
   always_comb begin
      en_d = en_q;
      if (wr_set) begin
         en_d = en_q | hwdata;
      end else if (wr_clr) begin
         en_d = en_q & ~hwdata;
      end
   end

   // Every bit is held at zero after reset so that no request can escape early.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         en_q <= UHIE_ENABLE_RST;
      end else begin
         en_q <= en_d;
      end
   end

   // ------------------------------------------------------------------
   // Status register.
   // ------------------------------------------------------------------
   assign evt_now = evt_vec(events);

   // Each event bit is sticky; a write clears the bits written as zero, and an event in the
   // same cycle wins over that clear so that it is never lost.
   // Reserved positions are tied to zero, so they read back as zero and never interrupt.
   generate
      for (genvar i = 0; i < 32; i++) begin : g_status
         if (UHIE_EVT_MASK[i]) begin : g_evt
            always_comb begin
               st_d[i] = evt_now[i] | (st_q[i] & ~(wr_st & ~hwdata[i]));
            end
         end else begin : g_none
            always_comb begin
               st_d[i] = 1'b0;
            end
         end
      end
   endgenerate

   // Status storage.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q <= UHIE_STATUS_RST;
      end else begin
         st_q <= st_d;
      end
   end

   // ------------------------------------------------------------------
   // Interrupt output.
   // ------------------------------------------------------------------
   uhie_evt_s req;

   // Each enable bit qualifies the status bit at the same position.
   assign req.ownership_change = st_q[UHIE_POS_OWN] & en_q[UHIE_POS_OWN];
   assign req.root_hub_change = st_q[UHIE_POS_HUB] & en_q[UHIE_POS_HUB];
   assign req.frame_number_overflow = st_q[UHIE_POS_FNO] & en_q[UHIE_POS_FNO];
   assign req.fatal_system_error = st_q[UHIE_POS_FATAL] & en_q[UHIE_POS_FATAL];
   assign req.resume_detect = st_q[UHIE_POS_RESUME] & en_q[UHIE_POS_RESUME];
   assign req.frame_start = st_q[UHIE_POS_SOF] & en_q[UHIE_POS_SOF];
   assign req.done_queue_writeback = st_q[UHIE_POS_DONE] & en_q[UHIE_POS_DONE];
   assign req.sched_overrun = st_q[UHIE_POS_OVR] & en_q[UHIE_POS_OVR];

   // A level from flip-flops only, so it drops in the same cycle as the cause clears.
   // The gate is applied last, so closing it drops the output without touching status.
   assign irq = en_q[UHIE_POS_GATE] & (|req);

   // ------------------------------------------------------------------
   // Assertions.
   // ------------------------------------------------------------------
   // Every check is held off while reset is low, except the one that watches the release.
   // They compare stored state against the write data and event pulses that caused it, so
   // a fault in the bus decode or the status update shows up here before it reaches the pin.

   // Reads of the clear port, which must show the enable register.
   sequence s_read_clear_port;
      take && !hwrite && haddr[UHIE_ADDR_W-1:0] == UHIE_OFS_ENABLE_CLEAR;
   endsequence

   // A status write that clears the frame start bit with no new frame behind it.
   sequence s_sof_cleared;
      wr_st && !hwdata[UHIE_POS_SOF] && !events.frame_start;
   endsequence

   // A status write that clears the frame start bit in the cycle in which a new frame starts.
   sequence s_sof_clear_race;
      wr_st && !hwdata[UHIE_POS_SOF] && events.frame_start;
   endsequence

   // A cycle in which no write reaches either port of the enable register.
   sequence s_enable_untouched;
      !wr_set && !wr_clr;
   endsequence

   // A status write of all zeros while no event arrives.
   sequence s_status_wiped;
      wr_st && hwdata == 32'h0000_0000 && evt_now == 32'h0000_0000;
   endsequence

   // The gate alone keeps the output quiet, whatever is pending, and closing it drops the level.
   a_gate_blocks_irq: assert property (@(posedge hclk) disable iff (!hresetn)
      !en_q[UHIE_POS_GATE] |-> !irq)
      else $error("interrupt raised with gate off");

   a_gate_drops_irq: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_clr && hwdata[UHIE_POS_GATE] |=> !irq)
      else $error("interrupt kept after gate closed");

   // Every source reaches the output on its own once its enable bit and the gate are set.
   a_own_raises_irq: assert property (@(posedge hclk) disable iff (!hresetn)
      st_q[UHIE_POS_OWN] && en_q[UHIE_POS_OWN] && en_q[UHIE_POS_GATE] |-> irq)
      else $error("ownership change request lost");

   a_hub_raises_irq: assert property (@(posedge hclk) disable iff (!hresetn)
      st_q[UHIE_POS_HUB] && en_q[UHIE_POS_HUB] && en_q[UHIE_POS_GATE] |-> irq)
      else $error("root hub change request lost");

   a_fno_raises_irq: assert property (@(posedge hclk) disable iff (!hresetn)
      st_q[UHIE_POS_FNO] && en_q[UHIE_POS_FNO] && en_q[UHIE_POS_GATE] |-> irq)
      else $error("frame number overflow request lost");

   a_fatal_raises_irq: assert property (@(posedge hclk) disable iff (!hresetn)
      st_q[UHIE_POS_FATAL] && en_q[UHIE_POS_FATAL] && en_q[UHIE_POS_GATE] |-> irq)
      else $error("fatal system error request lost");

   a_resume_raises_irq: assert property (@(posedge hclk) disable iff (!hresetn)
      st_q[UHIE_POS_RESUME] && en_q[UHIE_POS_RESUME] && en_q[UHIE_POS_GATE] |-> irq)
      else $error("resume detection request lost");

   a_done_raises_irq: assert property (@(posedge hclk) disable iff (!hresetn)
      st_q[UHIE_POS_DONE] && en_q[UHIE_POS_DONE] && en_q[UHIE_POS_GATE] |-> irq)
      else $error("done queue writeback request lost");

   a_ovr_raises_irq: assert property (@(posedge hclk) disable iff (!hresetn)
      st_q[UHIE_POS_OVR] && en_q[UHIE_POS_OVR] && en_q[UHIE_POS_GATE] |-> irq)
      else $error("scheduling overrun request lost");

   // A frame start with its enable and the gate set shows in status and output a cycle later.
   a_sof_raises_irq: assert property (@(posedge hclk) disable iff (!hresetn)
      events.frame_start && en_q[UHIE_POS_SOF] && en_q[UHIE_POS_GATE] && !wr_clr |=> st_q[UHIE_POS_SOF] && irq)
      else $error("frame start did not interrupt");

   // Enable register writes: the set port only adds, the clear port only removes.
   a_set_no_clear: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_set |=> en_q == ($past(en_q) | $past(hwdata)))
      else $error("enable set wrong");

   a_enable_holds: assert property (@(posedge hclk) disable iff (!hresetn)
      s_enable_untouched |=> $stable(en_q))
      else $error("enable changed without a write");

   a_set_port_read: assert property (@(posedge hclk) disable iff (!hresetn)
      take && !hwrite && haddr[UHIE_ADDR_W-1:0] == UHIE_OFS_ENABLE_SET |=> hrdata == en_q)
      else $error("set port read mismatch");

   a_clear_port_bits: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_clr |=> en_q == ($past(en_q) & ~$past(hwdata)))
      else $error("enable clear wrong");

   a_clear_port_read: assert property (@(posedge hclk) disable iff (!hresetn)
      s_read_clear_port |=> hrdata == en_q)
      else $error("clear port read mismatch");

   // Status bits land at the positions of their enables and nowhere else.
   a_event_lands: assert property (@(posedge hclk) disable iff (!hresetn)
      evt_now != 32'h0000_0000 |=> (st_q & $past(evt_now)) == $past(evt_now))
      else $error("event not at its enable position");

   a_status_no_reserved: assert property (@(posedge hclk) disable iff (!hresetn)
      (st_q & ~UHIE_EVT_MASK) == 32'h0000_0000)
      else $error("status set outside event positions");

   // The output needs a pending, enabled cause.
   a_irq_needs_cause: assert property (@(posedge hclk) disable iff (!hresetn)
      irq |-> |(st_q & en_q & UHIE_EVT_MASK))
      else $error("interrupt without cause");

   // Frame start status: sticky, cleared by a zero, and never lost to a clear in its own cycle.
   a_sof_sticky_set: assert property (@(posedge hclk) disable iff (!hresetn)
      events.frame_start |=> st_q[UHIE_POS_SOF] ##1 (st_q[UHIE_POS_SOF] || $past(wr_st)))
      else $error("frame start status not sticky");

   a_sof_zero_clear: assert property (@(posedge hclk) disable iff (!hresetn)
      s_sof_cleared |=> !st_q[UHIE_POS_SOF])
      else $error("frame start not cleared");

   a_sof_event_wins: assert property (@(posedge hclk) disable iff (!hresetn)
      s_sof_clear_race |=> st_q[UHIE_POS_SOF])
      else $error("frame start lost to a clear");

   // The level drops once its cause goes away.
   a_irq_drops: assert property (@(posedge hclk) disable iff (!hresetn)
      irq && wr_clr && hwdata[UHIE_POS_GATE] |=> !irq)
      else $error("interrupt level stuck");

   a_wipe_drops_irq: assert property (@(posedge hclk) disable iff (!hresetn)
      s_status_wiped |=> !irq)
      else $error("interrupt kept after status wiped");

   // Reset release leaves every enable off and the output quiet.
   a_reset_quiet: assert property (@(posedge hclk)
      $rose(hresetn) |-> en_q == UHIE_ENABLE_RST && !irq ##1 !irq)
      else $error("enable not cleared by reset");

endmodule // uhie_irq_mask
`default_nettype wire

//--- tb/uhie_irq_mask_test.sv
/*
   Self-checking testbench of the interrupt enable mask block: register access over AHB-Lite,
   the set and clear ports of the enable register, and the interrupt level for every source.
   Assumes the block answers with zero wait states, so hready is fed back from hreadyout.
*/
`timescale 1ns/10ps
`default_nettype none
module uhie_irq_mask_test import uhie_pkg::*;;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0000_0000;
   logic hready;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   uhie_evt_s events = '0;
   logic irq;
   int errors = 0;
   int checks_done = 0;
   // Defined enable positions; software keeps reserved bits at zero in every enable write.
   localparam logic [31:0] enable_bits = UHIE_EVT_MASK | (32'h1 << UHIE_POS_GATE);

   // -------------------------------------------------------------------
   // Clock, device and bus feedback.
   // -------------------------------------------------------------------
   // The single slave's ready is the bus ready.
   assign hready = hreadyout;
   initial begin
      forever #2 hclk = ~hclk;
   end
   uhie_irq_mask i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .events(events), .irq(irq));

   // -------------------------------------------------------------------
   // Reporting and shared bus tasks.
   // -------------------------------------------------------------------
   // Prints the counts and the verdict, then ends the run.
   task automatic print_verdict;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %0t %s: seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   // A bounded wait, so that a stuck ready cannot hang the run.
   task automatic wait_ready;
      int n;
      n = 0;
      @(posedge hclk);
      while (hready !== 1'b1) begin
         n++;
         if (n > 64) begin
            errors++;
            $display("[ERR] %0t bus ready never came", $time);
            print_verdict();
         end
         @(posedge hclk);
      end
   endtask
   // One single word transfer: address phase, then data phase; read data taken at its edge.
   task automatic ahb(input logic wr, input logic [7:0] ofs, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, ofs};
      hwrite <= wr;
      htrans <= UHIE_HTRANS_NONSEQ;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
      check({31'h0, hresp}, {31'h0, UHIE_HRESP_OKAY}, "response");
   endtask
   task automatic wr(input logic [7:0] ofs, input logic [31:0] wd);
      logic [31:0] unused;
      ahb(1'b1, ofs, wd, unused);
   endtask
   task automatic rd_chk(input logic [7:0] ofs, input logic [31:0] exp, input string what);
      logic [31:0] rd;
      ahb(1'b0, ofs, 32'h0000_0000, rd);
      check(rd, exp, what);
   endtask
   // The interrupt follows a register change in the same cycle; sample it a cycle on, once settled.
   task automatic irq_is(input logic exp, input string what);
      @(posedge hclk);
      #1;
      check({31'h0, irq}, {31'h0, exp}, what);
   endtask

   // -------------------------------------------------------------------
   // Scenarios.
   // -------------------------------------------------------------------
   // Nothing is enabled or pending out of reset.
   task automatic t_reset_values;
      irq_is(1'b0, "irq after reset");
      rd_chk(UHIE_OFS_ENABLE_SET, UHIE_ENABLE_RST, "enable after reset");
      rd_chk(UHIE_OFS_ENABLE_CLEAR, UHIE_ENABLE_RST, "clear port after reset");
      rd_chk(UHIE_OFS_STATUS, UHIE_STATUS_RST, "status after reset");
   endtask
   // Set and clear ports back to back, including zero bits and an unmapped offset.
   task automatic t_set_clear;
      wr(UHIE_OFS_ENABLE_SET, 32'h8000_0005);
      rd_chk(UHIE_OFS_ENABLE_SET, 32'h8000_0005, "set port sets");
      wr(UHIE_OFS_ENABLE_SET, 32'h0000_0002);
      rd_chk(UHIE_OFS_ENABLE_CLEAR, 32'h8000_0007, "zero bits kept, read via clear port");
      wr(UHIE_OFS_ENABLE_CLEAR, 32'h0000_0001);
      rd_chk(UHIE_OFS_ENABLE_SET, 32'h8000_0006, "clear port clears");
      wr(UHIE_OFS_ENABLE_CLEAR, 32'h0000_0000);
      rd_chk(UHIE_OFS_ENABLE_CLEAR, 32'h8000_0006, "zero clear ignored");
      rd_chk(8'h40, 32'h0000_0000, "unmapped read");
      wr(8'h40, 32'hffff_ffff);
      rd_chk(UHIE_OFS_ENABLE_SET, 32'h8000_0006, "unmapped write ignored");
      wr(UHIE_OFS_ENABLE_CLEAR, enable_bits);
      rd_chk(UHIE_OFS_ENABLE_SET, 32'h0000_0000, "all cleared");
   endtask
   // Every source in turn: masked, gated, enabled, disabled again, then its status cleared.
   task automatic t_sources;
      logic [31:0] m;
      for (int k = 0; k < 8; k++) begin
         m = (k == 7) ? (32'h1 << UHIE_POS_OWN) : (32'h1 << k);
         wr(UHIE_OFS_ENABLE_CLEAR, enable_bits);
         wr(UHIE_OFS_ENABLE_SET, (UHIE_EVT_MASK & ~m) | (32'h1 << UHIE_POS_GATE));
         @(posedge hclk);
         events <= uhie_evt_s'(8'h01 << k);
         @(posedge hclk);
         events <= '0;
         irq_is(1'b0, "other enables do not pass this source");
         rd_chk(UHIE_OFS_STATUS, m, "status bit at enable position");
         wr(UHIE_OFS_ENABLE_CLEAR, 32'h1 << UHIE_POS_GATE);
         wr(UHIE_OFS_ENABLE_SET, m);
         irq_is(1'b0, "gate closed");
         wr(UHIE_OFS_ENABLE_SET, 32'h1 << UHIE_POS_GATE);
         irq_is(1'b1, "source enabled");
         irq_is(1'b1, "level holds");
         wr(UHIE_OFS_ENABLE_CLEAR, m);
         irq_is(1'b0, "source disabled");
         wr(UHIE_OFS_ENABLE_SET, m);
         irq_is(1'b1, "source enabled again");
         wr(UHIE_OFS_STATUS, ~m);
         irq_is(1'b0, "status cleared by zero");
         rd_chk(UHIE_OFS_STATUS, 32'h0000_0000, "status empty");
      end
   endtask
   // A frame start in the very cycle of a status clear must survive; closing the gate drops the level.
   task automatic t_race_and_gate;
      wr(UHIE_OFS_ENABLE_SET, (32'h1 << UHIE_POS_SOF) | (32'h1 << UHIE_POS_GATE));
      @(posedge hclk);
      events.frame_start <= 1'b1;
      @(posedge hclk);
      events <= '0;
      irq_is(1'b1, "frame start raises irq directly");
      fork
         wr(UHIE_OFS_STATUS, 32'h0000_0000);
         begin
            repeat (2) @(posedge hclk);
            events.frame_start <= 1'b1;
            @(posedge hclk);
            events <= '0;
         end
      join
      rd_chk(UHIE_OFS_STATUS, 32'h1 << UHIE_POS_SOF, "event wins over clear");
      irq_is(1'b1, "level holds through the race");
      wr(UHIE_OFS_ENABLE_CLEAR, 32'h1 << UHIE_POS_GATE);
      irq_is(1'b0, "gate closed drops irq");
      wr(UHIE_OFS_STATUS, 32'h0000_0000);
      rd_chk(UHIE_OFS_STATUS, 32'h0000_0000, "status wiped");
      wr(UHIE_OFS_ENABLE_CLEAR, enable_bits);
   endtask
   // A reset in mid-run drops a pending interrupt and clears enables and status.
   task automatic t_mid_reset;
      wr(UHIE_OFS_ENABLE_SET, enable_bits);
      @(posedge hclk);
      events.root_hub_change <= 1'b1;
      @(posedge hclk);
      events <= '0;
      irq_is(1'b1, "pending before reset");
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      irq_is(1'b0, "irq after mid-run reset");
      rd_chk(UHIE_OFS_ENABLE_CLEAR, UHIE_ENABLE_RST, "enable after mid-run reset");
      rd_chk(UHIE_OFS_STATUS, UHIE_STATUS_RST, "status after mid-run reset");
   endtask

   // -------------------------------------------------------------------
   // Main sequence.
   // -------------------------------------------------------------------
   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset_values();
      t_set_clear();
      t_sources();
      t_race_and_gate();
      t_mid_reset();
      print_verdict();
   end
endmodule // uhie_irq_mask_test
`default_nettype wire
